// file: ltb_osc_ctrl.sv
// Control logic for the low-frequency timebase of the real-time clock.
// Assumes analog oscillator and INTERNAL_LOWFREQ_OSC deliver their outputs as asynchronous
// clock-rate inputs; the timer itself sits outside this block.
// ========================================
//
// The AXI4-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/1ns
module ltb_osc_ctrl #(
   parameter int BLANK_CYCLES = ltb_pkg::BLANK_CYC,
   parameter int FAIL_CYCLES = ltb_pkg::FAIL_CYC,
   parameter int STEP_CYCLES = ltb_pkg::STEP_CYC
) (
   input wire logic mclk,
   input wire logic reset,
   input wire logic clkEn,
   // AXI4-Lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Analog oscillator side
   input wire logic oscOut,
   input wire logic ampDetect,
   input wire logic lfoOut,
   output logic oscPowerEn,
   output logic crystalModeSelect,
   output logic gainControlEnable,
   output logic biasDoubleEnable,
   output logic pinShortEn,
   output logic [3:0] loadCapApplied,
   output logic lfoEnable,
   // Timebase out
   output logic tbClock,
   output logic tbIncBit1,
   output logic sysClkSelTb,
   output logic pinRouteTb
);
   // ========================================
   // Registers
   logic [6:0] oscCtrl_reg;
   logic [3:0] load_cap_select_reg;
   logic pinShort_reg;
   logic [1:0] clkSel_reg;
   logic [3:0] applied_reg;
   logic validFlag_reg;
   logic failFlag_reg;
   logic [31:0] blankCnt_reg;
   logic [31:0] failCnt_reg;
   logic [31:0] stepCnt_reg;
   logic [1:0] oscSync_reg;
   logic [1:0] ampSync_reg;
   logic [1:0] lfoSync_reg;
   logic oscPrev_reg;
   logic awHeld_reg;
   logic wHeld_reg;
   logic [7:0] awAddr_reg;
   logic [31:0] wData_reg;
   logic [3:0] wStrb_reg;
   logic bValid_reg;
   logic [1:0] bResp_reg;
   logic rValid_reg;
   logic [31:0] rData_reg;
   logic [1:0] rResp_reg;

   // Decodes an address to a mapped register
   function automatic logic isMapped(input logic [7:0] a);
      isMapped = (a == ltb_pkg::OSC_CTRL_ADDR) || (a == ltb_pkg::LOAD_CAP_ADDR) ||
         (a == ltb_pkg::PIN_SHORT_ADDR) || (a == ltb_pkg::STATUS_ADDR) ||
         (a == ltb_pkg::CLK_SEL_ADDR);
   endfunction : isMapped

   // ========================================
   // Write channel: address and data taken in either order
   // Both channels stay refused while a response waits, so one write is in flight
   logic doWrite;
   assign s_axi_awready = !awHeld_reg && !bValid_reg;
   assign s_axi_wready = !wHeld_reg && !bValid_reg;
   assign doWrite = awHeld_reg && wHeld_reg && !bValid_reg;

   always_ff @(posedge mclk) begin
      if (reset) begin
         awHeld_reg <= 1'b0;
         wHeld_reg <= 1'b0;
         awAddr_reg <= 8'h00;
         wData_reg <= 32'h0;
         wStrb_reg <= 4'h0;
         bValid_reg <= 1'b0;
         bResp_reg <= ltb_pkg::RESP_OKAY;
      end else if (clkEn) begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld_reg <= 1'b1;
            awAddr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld_reg <= 1'b1;
            wData_reg <= s_axi_wdata;
            wStrb_reg <= s_axi_wstrb;
         end
         if (doWrite) begin
            awHeld_reg <= 1'b0;
            wHeld_reg <= 1'b0;
            bValid_reg <= 1'b1;
            bResp_reg <= isMapped(awAddr_reg) ? ltb_pkg::RESP_OKAY : ltb_pkg::RESP_SLVERR;
         end else if (bValid_reg && s_axi_bready) begin
            bValid_reg <= 1'b0;
         end
      end
   end
   assign s_axi_bvalid = bValid_reg;
   assign s_axi_bresp = bResp_reg;

   // ========================================
   // Control registers; only byte lane 0 holds fields
   always_ff @(posedge mclk) begin
      if (reset) begin
         oscCtrl_reg <= ltb_pkg::OSC_CTRL_RST;
         load_cap_select_reg <= ltb_pkg::LOAD_CAP_RST;
         pinShort_reg <= 1'b0;
         clkSel_reg <= 2'h0;
      end else if (clkEn && doWrite && wStrb_reg[0]) begin
         unique case (awAddr_reg)
            ltb_pkg::OSC_CTRL_ADDR: oscCtrl_reg <= wData_reg[6:0];
            ltb_pkg::LOAD_CAP_ADDR: load_cap_select_reg <= wData_reg[3:0];
            ltb_pkg::PIN_SHORT_ADDR: pinShort_reg <= wData_reg[0];
            ltb_pkg::CLK_SEL_ADDR: clkSel_reg <= wData_reg[1:0];
            default: ;
         endcase
      end
   end

   // ========================================
   // Read channel
   logic [31:0] statusWord;
   assign statusWord = {24'h0, applied_reg, 1'b0, failFlag_reg,
      (applied_reg == load_cap_select_reg), validFlag_reg};
   assign s_axi_arready = !rValid_reg;

   always_ff @(posedge mclk) begin
      if (reset) begin
         rValid_reg <= 1'b0;
         rData_reg <= 32'h0;
         rResp_reg <= ltb_pkg::RESP_OKAY;
      end else if (clkEn) begin
         if (s_axi_arvalid && s_axi_arready) begin
            rValid_reg <= 1'b1;
            rResp_reg <= isMapped(s_axi_araddr) ? ltb_pkg::RESP_OKAY : ltb_pkg::RESP_SLVERR;
            unique case (s_axi_araddr)
               ltb_pkg::OSC_CTRL_ADDR: rData_reg <= {25'h0, oscCtrl_reg};
               ltb_pkg::LOAD_CAP_ADDR: rData_reg <= {28'h0, load_cap_select_reg};
               ltb_pkg::PIN_SHORT_ADDR: rData_reg <= {31'h0, pinShort_reg};
               ltb_pkg::STATUS_ADDR: rData_reg <= statusWord;
               ltb_pkg::CLK_SEL_ADDR: rData_reg <= {30'h0, clkSel_reg};
               default: rData_reg <= 32'h0;
            endcase
         end else if (rValid_reg && s_axi_rready) begin
            rValid_reg <= 1'b0;
         end
      end
   end
   assign s_axi_rvalid = rValid_reg;
   assign s_axi_rdata = rData_reg;
   assign s_axi_rresp = rResp_reg;

   // ========================================
   // Synchronisers for the asynchronous oscillator signals
   // Only the second stage is read; the first may still be settling
   always_ff @(posedge mclk) begin
      if (reset) begin
         oscSync_reg <= 2'b00;
         ampSync_reg <= 2'b00;
         lfoSync_reg <= 2'b00;
         oscPrev_reg <= 1'b0;
      end else if (clkEn) begin
         oscSync_reg <= {oscSync_reg[0], oscOut};
         ampSync_reg <= {ampSync_reg[0], ampDetect};
         lfoSync_reg <= {lfoSync_reg[0], lfoOut};
         oscPrev_reg <= oscSync_reg[1];
      end
   end

   // ========================================
   // Clock-valid with blanking after crystal power-on
   // Amplitude alone cannot vouch for an external clock; the fail flag does that
   logic crystalOn;
   assign crystalOn = oscCtrl_reg[ltb_pkg::POWER_BIT] && oscCtrl_reg[ltb_pkg::CRYSTAL_BIT];

   always_ff @(posedge mclk) begin
      if (reset) begin
         blankCnt_reg <= 32'h0;
         validFlag_reg <= 1'b0;
      end else if (clkEn) begin
         if (!crystalOn) begin
            blankCnt_reg <= 32'h0;
            validFlag_reg <= 1'b0;
         end else if (blankCnt_reg < 32'(BLANK_CYCLES)) begin
            blankCnt_reg <= blankCnt_reg + 32'h1;
            validFlag_reg <= 1'b0;
         end else begin
            validFlag_reg <= ampSync_reg[1]; // amplitude only, meaningless on an external clock
         end
      end
   end

   // ========================================
   // Missing clock detector; one-shot, flag cleared only when detector is disabled
   logic mcdEn;
   assign mcdEn = oscCtrl_reg[ltb_pkg::MCD_BIT];

   always_ff @(posedge mclk) begin
      if (reset) begin
         failCnt_reg <= 32'h0;
         failFlag_reg <= 1'b0;
      end else if (clkEn) begin
         if (!mcdEn) begin
            failCnt_reg <= 32'h0;
            failFlag_reg <= 1'b0;
         end else if (oscSync_reg[1] != oscPrev_reg) begin
            failCnt_reg <= 32'h0;
         end else if (failCnt_reg < 32'(FAIL_CYCLES)) begin
            failCnt_reg <= failCnt_reg + 32'h1;
         end else begin
            failFlag_reg <= 1'b1;
         end
      end
   end

   // ========================================
   // Load capacitance stepping; slow steps give the crystal a fast startup
   // A lowered program snaps down at once rather than stepping back
   always_ff @(posedge mclk) begin
      if (reset) begin
         applied_reg <= ltb_pkg::LOAD_CAP_MIN;
         stepCnt_reg <= 32'h0;
      end else if (clkEn) begin
         if (!oscCtrl_reg[ltb_pkg::AUTOSTEP_BIT]) begin
            applied_reg <= load_cap_select_reg;
            stepCnt_reg <= 32'h0;
         end else if (!oscCtrl_reg[ltb_pkg::POWER_BIT]) begin
            applied_reg <= ltb_pkg::LOAD_CAP_MIN;
            stepCnt_reg <= 32'h0;
         end else if (applied_reg > load_cap_select_reg) begin
            applied_reg <= load_cap_select_reg;
         end else if (applied_reg != load_cap_select_reg) begin
            if (stepCnt_reg >= 32'(STEP_CYCLES - 1)) begin
               stepCnt_reg <= 32'h0;
               applied_reg <= applied_reg + 4'h1;
            end else begin
               stepCnt_reg <= stepCnt_reg + 32'h1;
            end
         end
      end
   end

   // ========================================
   // Outputs to the analog section and timebase routing
   assign oscPowerEn = oscCtrl_reg[ltb_pkg::POWER_BIT];
   assign crystalModeSelect = oscCtrl_reg[ltb_pkg::CRYSTAL_BIT];
   assign gainControlEnable = oscCtrl_reg[ltb_pkg::GAIN_BIT];
   assign biasDoubleEnable = oscCtrl_reg[ltb_pkg::BIAS_BIT];
   assign lfoEnable = oscCtrl_reg[ltb_pkg::LOWFREQ_OSC_BIT];
   assign pinShortEn = pinShort_reg;
   assign loadCapApplied = applied_reg;
   assign tbClock = lfoEnable ? lfoSync_reg[1] : oscSync_reg[1];
   assign tbIncBit1 = lfoEnable;
   assign sysClkSelTb = clkSel_reg[0];
   assign pinRouteTb = clkSel_reg[1];
endmodule : ltb_osc_ctrl

// file: ltb_osc_ctrl_props.sv
// Checker for the timebase control block, watching its ports only.
// Assumes it is bound to ltb_osc_ctrl with a reset asserted first.
`timescale 1ns/1ns
module ltb_osc_ctrl_props (
   input wire logic mclk,
   input wire logic reset,
   input wire logic s_axi_awready,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic oscPowerEn,
   input wire logic crystalModeSelect,
   input wire logic biasDoubleEnable,
   input wire logic pinShortEn,
   input wire logic [3:0] loadCapApplied,
   input wire logic lfoEnable,
   input wire logic tbIncBit1,
   input wire logic sysClkSelTb,
   input wire logic pinRouteTb
);
   // ========================================
   // Helper logic
   logic [7:0] arAddr;
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   always_ff @(posedge mclk) begin
      if (s_axi_arvalid && s_axi_arready) begin
         arAddr <= s_axi_araddr;
      end
   end
   sequence s_bhold;
      s_axi_bvalid && !s_axi_bready;
   endsequence
   sequence s_rhold;
      s_axi_rvalid && !s_axi_rready;
   endsequence
   // ========================================
   // Properties
   property p_incbit;
      tbIncBit1 == lfoEnable;
   endproperty
   property p_ctrlupd;
      $changed({lfoEnable, biasDoubleEnable, crystalModeSelect, pinShortEn, sysClkSelTb,
         pinRouteTb}) |-> $rose(s_axi_bvalid);
   endproperty
   // Only a write may make the applied code jump; stepping moves it by one
   property p_capstep;
      $changed(loadCapApplied) && (loadCapApplied != $past(loadCapApplied) + 4'h1)
         |-> (s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2));
   endproperty
   property p_bstand;
      s_bhold |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   property p_rstand;
      s_rhold |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
   endproperty
   property p_arblock;
      s_axi_rvalid |-> !s_axi_arready;
   endproperty
   property p_wblock;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   property p_unmap;
      s_axi_rvalid && (arAddr > ltb_pkg::CLK_SEL_ADDR)
         |-> s_axi_rresp == ltb_pkg::RESP_SLVERR && s_axi_rdata == 32'h0;
   endproperty
   a_incbit: assert property (p_incbit) else $error("increment bit differs from lfo enable");
   a_ctrlupd: assert property (p_ctrlupd) else $error("control output moved without write");
   a_capstep: assert property (p_capstep) else $error("applied cap jumped");
   a_bstand: assert property (p_bstand) else $error("write response dropped");
   a_rstand: assert property (p_rstand) else $error("read data dropped");
   a_arblock: assert property (p_arblock) else $error("read taken while answering");
   a_wblock: assert property (p_wblock) else $error("write taken while answering");
   a_unmap: assert property (p_unmap) else $error("unmapped read not refused");
endmodule : ltb_osc_ctrl_props
bind ltb_osc_ctrl ltb_osc_ctrl_props i_ltb_osc_ctrl_props (.mclk(mclk), .reset(reset),
   .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .oscPowerEn(oscPowerEn),
   .crystalModeSelect(crystalModeSelect), .biasDoubleEnable(biasDoubleEnable),
   .pinShortEn(pinShortEn), .loadCapApplied(loadCapApplied), .lfoEnable(lfoEnable),
   .tbIncBit1(tbIncBit1), .sysClkSelTb(sysClkSelTb), .pinRouteTb(pinRouteTb));

// file: ltb_osc_model.sv
// Behavioural crystal and low-frequency oscillator beside the block.
// Assumes mclk is far faster than either oscillator, so rates are scaled.
`timescale 1ns/1ns
module ltb_osc_model #(
   parameter int HALF = 3
) (
   input wire logic mclk,
   input wire logic powerOn,
   input wire logic stall,
   input wire logic lfoOn,
   output logic oscOut,
   output logic ampDetect,
   output logic lfoOut
);
   int cnt = 0;
   logic oscReg = 1'b0;
   logic ampReg = 1'b0;
   logic lfoReg = 1'b0;
   assign oscOut = oscReg;
   assign ampDetect = ampReg;
   assign lfoOut = lfoReg;
   always @(posedge mclk) begin
      cnt <= (cnt + 1) % (2 * HALF);
      // Stall stands in for a dead crystal; an unpowered one stays still
      if (powerOn && !stall && (cnt % HALF == 0)) oscReg <= ~oscReg;
      ampReg <= powerOn && !stall;
      if (lfoOn && cnt == 0) lfoReg <= ~lfoReg;
   end
endmodule : ltb_osc_model

// file: ltb_pkg.sv
// Package for the low-frequency timebase oscillator control block.
// Assumes a 250 MHz mclk and an AXI4-Lite register bus with 32-bit data.
package ltb_pkg;
   // ========================================
   // Register byte addresses
   localparam logic [7:0] OSC_CTRL_ADDR = 8'h00;
   localparam logic [7:0] LOAD_CAP_ADDR = 8'h04;
   localparam logic [7:0] PIN_SHORT_ADDR = 8'h08;
   localparam logic [7:0] STATUS_ADDR = 8'h0c;
   localparam logic [7:0] CLK_SEL_ADDR = 8'h10;
   // ========================================
   // Oscillator control field positions
   localparam int POWER_BIT = 0;
   localparam int CRYSTAL_BIT = 1;
   localparam int GAIN_BIT = 2;
   localparam int BIAS_BIT = 3;
   localparam int MCD_BIT = 4;
   localparam int LOWFREQ_OSC_BIT = 5;
   localparam int AUTOSTEP_BIT = 6;
   // Status field positions
   localparam int VALID_BIT = 0;
   localparam int LOAD_READY_BIT = 1;
   localparam int FAIL_BIT = 2;
   localparam int APPLIED_LSB = 4;
   localparam int LOAD_CAP_W = 4;
   // ========================================
   // Reset values
   localparam logic [6:0] OSC_CTRL_RST = 7'h00;
   localparam logic [3:0] LOAD_CAP_RST = 4'h0;
   localparam logic [3:0] LOAD_CAP_MIN = 4'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ========================================
   // Timing
   localparam int MCLK_MHZ = 250;
   localparam int BLANK_US = 2000;
   localparam int FAIL_US = 100;
   localparam int STEP_US = 1000;
   localparam int BLANK_CYC = BLANK_US * MCLK_MHZ;
   localparam int FAIL_CYC = FAIL_US * MCLK_MHZ;
   localparam int STEP_CYC = STEP_US * MCLK_MHZ;
endpackage : ltb_pkg

// file: tb.sv
// Self-checking bench for the timebase control block.
// Assumes short counts: blank 20, fail 10, step 4 cycles.
`timescale 1ns/1ns
module tb;
   logic mclk = 1'b0, reset = 1'b1, stall = 1'b0, clkEn = 1'b1;
   logic [7:0] awaddr = 8'h0, araddr = 8'h0;
   logic [31:0] wdata = 32'h0, rdata, rd;
   logic [3:0] wstrb = 4'h0, cap;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, osc, amp, internal_lowfreq_osc, pwr, xm, gain, bias, psh;
   logic internal_lowfreq_osc_enable, tbClk, inc1, sel, route;
   logic [1:0] bresp, rresp, wrsp, rsp;
   int bad_count = 0, checked = 0, cyc = 0, tg;
   always #2 mclk = ~mclk;
   ltb_osc_ctrl #(.BLANK_CYCLES(20), .FAIL_CYCLES(10), .STEP_CYCLES(4)) i_ltb_osc_ctrl (
      .mclk(mclk), .reset(reset), .clkEn(clkEn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .oscOut(osc), .ampDetect(amp), .lfoOut(internal_lowfreq_osc), .oscPowerEn(pwr),
      .crystalModeSelect(xm), .gainControlEnable(gain), .biasDoubleEnable(bias),
      .pinShortEn(psh), .loadCapApplied(cap), .lfoEnable(internal_lowfreq_osc_enable), .tbClock(tbClk),
      .tbIncBit1(inc1), .sysClkSelTb(sel), .pinRouteTb(route));
   ltb_osc_model #(.HALF(3)) i_ltb_osc_model (.mclk(mclk), .powerOn(pwr), .stall(stall),
      .lfoOn(internal_lowfreq_osc_enable), .oscOut(osc), .ampDetect(amp), .lfoOut(internal_lowfreq_osc));
   // ========================================
   // Tasks
   task automatic conclude();
      if (bad_count == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : conclude
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge mclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge mclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      wrsp = bresp;
      bready <= 1'b0;
   endtask : axw
   task automatic axr(input logic [7:0] a);
      @(posedge mclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge mclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rd = rdata;
      rsp = rresp;
      rready <= 1'b0;
   endtask : axr
   task automatic poll(input int b);
      for (int n = 0; n < 40 && rd[b] !== 1'b1; n++) axr(ltb_pkg::STATUS_ADDR);
      chk(32'(rd[b]), 32'h1);
   endtask : poll
   // ========================================
   // Timeout and main sequence
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         conclude();
      end
   end
   initial begin
      repeat (10) @(posedge mclk);
      reset <= 1'b0;
      axr(ltb_pkg::OSC_CTRL_ADDR);
      chk(rd, 32'h0);
      axr(ltb_pkg::STATUS_ADDR);
      chk(rd, 32'h2);
      axr(8'h40);
      chk(rd | 32'(rsp), 32'(ltb_pkg::RESP_SLVERR));
      for (int i = 0; i < 16; i++) begin
         axw(ltb_pkg::LOAD_CAP_ADDR, 32'(i), 4'hf);
         axr(ltb_pkg::STATUS_ADDR);
         chk(rd & 32'hf2, (32'(i) << 4) | 32'h2);
      end
      axw(ltb_pkg::LOAD_CAP_ADDR, 32'h3, 4'h0);
      axr(ltb_pkg::LOAD_CAP_ADDR);
      chk(rd, 32'hf);
      axw(8'h40, 32'hff, 4'hf);
      chk(32'(wrsp), 32'(ltb_pkg::RESP_SLVERR));
      axw(ltb_pkg::OSC_CTRL_ADDR, 32'h4a, 4'hf);
      chk(32'({xm, gain, bias}), 32'h5);
      axw(ltb_pkg::LOAD_CAP_ADDR, 32'h5, 4'hf);
      axw(ltb_pkg::OSC_CTRL_ADDR, 32'h4b, 4'hf);
      chk(32'(wrsp), 32'(ltb_pkg::RESP_OKAY));
      axr(ltb_pkg::STATUS_ADDR);
      chk(rd & 32'h3, 32'h0);
      poll(ltb_pkg::VALID_BIT);
      poll(ltb_pkg::LOAD_READY_BIT);
      chk(32'(cap), 32'h5);
      axw(ltb_pkg::OSC_CTRL_ADDR, 32'h57, 4'hf);
      axr(ltb_pkg::STATUS_ADDR);
      chk(32'(rd[2]), 32'h0);
      axw(ltb_pkg::OSC_CTRL_ADDR, 32'h13, 4'hf);
      chk(32'({xm, gain, bias}), 32'h4);
      repeat (20) @(posedge mclk);
      axr(ltb_pkg::STATUS_ADDR);
      chk(32'(rd[2]), 32'h0);
      stall <= 1'b1;
      poll(ltb_pkg::FAIL_BIT);
      axw(ltb_pkg::OSC_CTRL_ADDR, 32'h09, 4'hf);
      chk(32'({xm, gain, bias, pwr}), 32'h3);
      axw(ltb_pkg::LOAD_CAP_ADDR, 32'hc, 4'hf);
      axr(ltb_pkg::STATUS_ADDR);
      chk(rd & 32'hf7, 32'hc2);
      axw(ltb_pkg::OSC_CTRL_ADDR, 32'h20, 4'hf);
      chk(32'({internal_lowfreq_osc_enable, inc1, pwr}), 32'h6);
      tg = 0;
      repeat (40) @(posedge mclk) tg += 32'(tbClk);
      chk(32'(tg > 0 && tg < 40), 32'h1);
      clkEn <= 1'b0;
      tg = 0;
      repeat (24) @(posedge mclk) tg += 32'(tbClk);
      chk(32'(tg == 0 || tg == 24), 32'h1);
      clkEn <= 1'b1;
      axw(ltb_pkg::PIN_SHORT_ADDR, 32'h1, 4'hf);
      axw(ltb_pkg::CLK_SEL_ADDR, 32'h3, 4'hf);
      chk(32'({psh, sel, route}), 32'h7);
      chk(32'(wrsp), 32'(ltb_pkg::RESP_OKAY));
      reset <= 1'b1;
      repeat (2) @(posedge mclk);
      reset <= 1'b0;
      chk(32'({psh, sel, route, internal_lowfreq_osc_enable, cap}), 32'h0);
      axr(ltb_pkg::CLK_SEL_ADDR);
      chk(rd, 32'h0);
      conclude();
   end
endmodule : tb
